// ### include/hbss_defs.svh
// Purpose: offsets, field positions, reset values and timing for the
//          holding brake stop sequencer
// Assumes: 32-bit apb data, 8-bit byte address
// Notes:   definitions only
`ifndef HBSS_DEFS_SVH
`define HBSS_DEFS_SVH
// register byte offsets
`define HBSS_OFS_CFG 8'h00
`define HBSS_OFS_DELAY 8'h04
`define HBSS_OFS_SPEED 8'h08
`define HBSS_OFS_WAIT 8'h0c
`define HBSS_OFS_MAXSPD 8'h10
`define HBSS_OFS_STATUS 8'h14
`define HBSS_OFS_RESTART 8'h18
`define HBSS_OFS_IRQ_STAT 8'h1c
`define HBSS_OFS_IRQ_CLR 8'h20
`define HBSS_OFS_IRQ_EN 8'h24
// cfg field positions (pending copy, applied on restart)
`define HBSS_CFG_ALLOC_LSB 0
`define HBSS_CFG_SOFF_LSB 2
`define HBSS_CFG_G2_BIT 4
// reset values and limits of the settings
`define HBSS_CFG_RST 5'h00
`define HBSS_DELAY_RST 6'h00
`define HBSS_DELAY_MAX 6'h32
`define HBSS_SPEED_RST 14'h0064
`define HBSS_SPEED_MAX 14'h2710
`define HBSS_WAIT_RST 7'h32
`define HBSS_WAIT_MIN 7'h0a
`define HBSS_WAIT_MAX 7'h64
`define HBSS_MAXSPD_RST 14'h1770
`define HBSS_ZERO_SPEED 14'h0014
// stop method codes
`define HBSS_SOFF_COAST 2'h2
`define HBSS_SOFF_DB_HOLD 2'h0
// interrupt bits
`define HBSS_IRQ_BRAKE 0
`define HBSS_IRQ_PWROFF 1
`define HBSS_IRQ_ALARM 2
`define HBSS_IRQ_TIMEOUT 3
// timing: tick period in ms, clock rate in MHz
`define HBSS_TICK_MS 10
`define HBSS_CLK_MHZ 200
`define HBSS_TICK_CYCLES (`HBSS_TICK_MS * 1000 * `HBSS_CLK_MHZ)
`endif

// ### include/hbss_pkg.sv
// Purpose: types of the holding brake stop sequencer
// Assumes: nothing beyond the defs header
// Notes:   the whole module state is one packed struct
package hbss_pkg;
  // sequencer states
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,   // power off, brake applied
    ST_ON = 3'b001,    // power on, brake released
    ST_DELAY = 3'b010, // brake applied, power held for the delay
    ST_WAIT = 3'b011,  // power off, rotating, brake still released
    ST_ZSTOP = 3'b100  // zero-speed stop under power
  } hbss_state_t;

  // complete register state of the block
  typedef struct packed {
    logic [1:0] son_sync_reg;
    logic [1:0] soff_sync_reg;
    logic son_d_reg;
    logic soff_d_reg;
    logic servo_req_reg;
    hbss_state_t state_reg;
    logic [6:0] cnt_reg;
    logic [31:0] pre_reg;
    logic [4:0] cfg_reg;
    logic [1:0] alloc_reg;
    logic [1:0] soff_reg;
    logic g2_reg;
    logic [5:0] delay_reg;
    logic [13:0] speed_reg;
    logic [6:0] wait_reg;
    logic [13:0] maxspd_reg;
    logic [3:0] irq_stat_reg;
    logic [3:0] irq_en_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic [2:0] term_reg;
    logic brk_reg;
    logic pwr_reg;
    logic db_reg;
    logic zstop_reg;
  } hbss_regs_t;
endpackage

// ### src/hbss_sequencer.sv
// Purpose: holding brake output and motor stop sequencing, apb registers
// Assumes: alarms, speed, torque mode and other outputs come from logic
//          on pclk; servo commands are pins
// Notes:
`timescale 1ns/100ps
`include "hbss_defs.svh"

module hbss_sequencer #(
  parameter int unsigned TICK_CYCLES = `HBSS_TICK_CYCLES, // cycles per tick
  parameter logic [13:0] ZERO_SPEED = `HBSS_ZERO_SPEED,  // stationary limit
  parameter logic [13:0] MAX_SPEED_RST = `HBSS_MAXSPD_RST // motor max rpm
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic servo_on_cmd,
  input wire logic servo_off_cmd,
  input wire logic alarm_group_one,
  input wire logic alarm_group_two,
  input wire logic torque_mode,
  input wire logic [13:0] motor_speed,
  input wire logic [2:0] other_out_func,
  output logic brake_release_out,
  output logic [2:0] out_term,
  output logic motor_power_on,
  output logic dynamic_brake,
  output logic zero_speed_stop,
  output logic irq
);
  import hbss_pkg::*;

  hbss_regs_t st_reg;  // registered state
  hbss_regs_t st_next; // next value
  logic son_rise;      // servo-on edge after sync
  logic soff_rise;     // servo-off edge after sync
  logic g2_zero;       // group two alarm asking zero-speed stop
  logic hard_alarm;    // alarm that cuts power at once
  logic stationary;    // motor counts as stopped
  logic [13:0] eff_thr; // clamped brake speed threshold
  logic below_thr;     // speed under effective threshold
  logic tick;          // one-cycle 10 ms enable
  logic wr_access;     // apb write in access phase
  logic [3:0] irq_ev;  // events this cycle
  logic [2:0] term_c;  // terminal values before the register

  // address decode used by the error path; the read path decodes in its own case
  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      `HBSS_OFS_CFG, `HBSS_OFS_DELAY, `HBSS_OFS_SPEED, `HBSS_OFS_WAIT,
      `HBSS_OFS_MAXSPD, `HBSS_OFS_STATUS, `HBSS_OFS_RESTART,
      `HBSS_OFS_IRQ_STAT, `HBSS_OFS_IRQ_CLR, `HBSS_OFS_IRQ_EN: begin
        return 1'b1;
      end
      default: begin
        return 1'b0;
      end
    endcase
  endfunction

  // brake released only while power is on or the motor is still spinning
  function automatic logic brk_of(input hbss_state_t s);
    return (s == ST_ON) || (s == ST_ZSTOP) || (s == ST_WAIT);
  endfunction

  // power on until the delay expires; never in wait or off
  function automatic logic pwr_of(input hbss_state_t s);
    return (s == ST_ON) || (s == ST_ZSTOP) || (s == ST_DELAY);
  endfunction

  // edge detect reads only the second sync stage
  assign son_rise = st_reg.son_sync_reg[1] & ~st_reg.son_d_reg;
  assign soff_rise = st_reg.soff_sync_reg[1] & ~st_reg.soff_d_reg;

  // group two honours its own field only outside torque control
  assign g2_zero = alarm_group_two & ~alarm_group_one & ~torque_mode &
                   ~st_reg.g2_reg;
  assign hard_alarm = alarm_group_one | (alarm_group_two & ~g2_zero);

  // threshold can never exceed what the motor can reach
  assign eff_thr = (st_reg.speed_reg > st_reg.maxspd_reg) ?
                   st_reg.maxspd_reg : st_reg.speed_reg;
  assign below_thr = motor_speed < eff_thr;
  assign stationary = motor_speed < ZERO_SPEED;

  // tick divider; restarted when an interval starts so it is exact
  assign tick = (st_reg.pre_reg == 32'(TICK_CYCLES - 1));
  assign wr_access = psel & penable & pwrite;

  // terminal mux: each pair is brake (if routed) OR its other function
  // next allocation, so a restart moves routing and brake in one edge
  for (genvar i = 0; i < 3; i++) begin : g_term
    assign term_c[i] = ((st_next.alloc_reg == 2'(i + 1)) & st_next.brk_reg) |
                       other_out_func[i];
  end

  // next-state logic for the whole block
  always_comb begin
    st_next = st_reg;
    irq_ev = 4'h0;
    // two-stage synchronisers on the command pins
    st_next.son_sync_reg = {st_reg.son_sync_reg[0], servo_on_cmd};
    st_next.soff_sync_reg = {st_reg.soff_sync_reg[0], servo_off_cmd};
    st_next.son_d_reg = st_reg.son_sync_reg[1];
    st_next.soff_d_reg = st_reg.soff_sync_reg[1];
    // servo request latch; off and alarms win over on
    if (son_rise) begin
      st_next.servo_req_reg = 1'b1;
    end
    if (soff_rise || alarm_group_one || alarm_group_two) begin
      st_next.servo_req_reg = 1'b0;
    end
    // prescaler free-runs; loads below reset it
    st_next.pre_reg = tick ? 32'h0 : st_reg.pre_reg + 32'h1;
    if (tick && (st_reg.cnt_reg != 7'h0)) begin
      st_next.cnt_reg = st_reg.cnt_reg - 7'h1;
    end
    // sequencer
    case (st_reg.state_reg)
      ST_OFF: begin
        // restart of power needs a live request and no alarm
        if (st_reg.servo_req_reg && !soff_rise && !alarm_group_one &&
            !alarm_group_two) begin
          st_next.state_reg = ST_ON;
        end
      end
      ST_ON, ST_ZSTOP: begin
        if (hard_alarm) begin
          irq_ev[`HBSS_IRQ_ALARM] = (st_reg.state_reg == ST_ON);
          if (stationary) begin
            st_next.state_reg = ST_OFF;
          end else begin
            st_next.state_reg = ST_WAIT;
            st_next.cnt_reg = st_reg.wait_reg;
            st_next.pre_reg = 32'h0;
          end
        end else if (g2_zero && st_reg.state_reg == ST_ON) begin
          irq_ev[`HBSS_IRQ_ALARM] = 1'b1;
          st_next.state_reg = ST_ZSTOP;
        end else if (st_reg.state_reg == ST_ZSTOP ? stationary :
                     (soff_rise || !st_reg.servo_req_reg)) begin
          // stopped: brake now, power after the programmed delay
          if (!stationary) begin
            st_next.state_reg = ST_WAIT;
            st_next.cnt_reg = st_reg.wait_reg;
            st_next.pre_reg = 32'h0;
          end else if (st_reg.delay_reg == 6'h0) begin
            st_next.state_reg = ST_OFF;
          end else begin
            st_next.state_reg = ST_DELAY;
            st_next.cnt_reg = {1'b0, st_reg.delay_reg};
            st_next.pre_reg = 32'h0;
          end
        end
      end
      ST_DELAY: begin
        // a hard alarm overrides the delay and drops power now
        if (hard_alarm || st_reg.cnt_reg == 7'h0) begin
          st_next.state_reg = ST_OFF;
        end
      end
      ST_WAIT: begin
        // whichever comes first: slow enough, or waited long enough
        if (below_thr || st_reg.cnt_reg == 7'h0) begin
          st_next.state_reg = ST_OFF;
          irq_ev[`HBSS_IRQ_TIMEOUT] = !below_thr;
        end
      end
      default: begin
        st_next.state_reg = ST_OFF;
      end
    endcase
    // apb writes take effect in the access phase
    if (wr_access) begin
      case (paddr)
        `HBSS_OFS_CFG: begin
          st_next.cfg_reg = pwdata[4:0];
        end
        `HBSS_OFS_DELAY: begin
          st_next.delay_reg = (pwdata[5:0] > `HBSS_DELAY_MAX ||
                               pwdata[31:6] != 26'h0) ?
                              `HBSS_DELAY_MAX : pwdata[5:0];
        end
        `HBSS_OFS_SPEED: begin
          st_next.speed_reg = (pwdata[13:0] > `HBSS_SPEED_MAX ||
                               pwdata[31:14] != 18'h0) ?
                              `HBSS_SPEED_MAX : pwdata[13:0];
        end
        `HBSS_OFS_WAIT: begin
          if (pwdata[6:0] > `HBSS_WAIT_MAX || pwdata[31:7] != 25'h0) begin
            st_next.wait_reg = `HBSS_WAIT_MAX;
          end else if (pwdata[6:0] < `HBSS_WAIT_MIN) begin
            st_next.wait_reg = `HBSS_WAIT_MIN;
          end else begin
            st_next.wait_reg = pwdata[6:0];
          end
        end
        `HBSS_OFS_MAXSPD: begin
          st_next.maxspd_reg = pwdata[13:0];
        end
        `HBSS_OFS_RESTART: begin
          // restart-only fields become live here
          if (pwdata[0]) begin
            st_next.alloc_reg =
              st_reg.cfg_reg[`HBSS_CFG_ALLOC_LSB +: 2];
            st_next.soff_reg =
              st_reg.cfg_reg[`HBSS_CFG_SOFF_LSB +: 2];
            st_next.g2_reg = st_reg.cfg_reg[`HBSS_CFG_G2_BIT];
          end
        end
        `HBSS_OFS_IRQ_EN: begin
          st_next.irq_en_reg = pwdata[3:0];
        end
        default: begin
        end
      endcase
    end
    // outputs follow the next state so they change with it
    st_next.brk_reg = brk_of(st_next.state_reg);
    st_next.pwr_reg = pwr_of(st_next.state_reg);
    st_next.zstop_reg = (st_next.state_reg == ST_ZSTOP);
    // db while stopping unless coast; held after stop only in mode 0
    st_next.db_reg =
      ((st_next.state_reg == ST_WAIT) &&
       (st_next.soff_reg != `HBSS_SOFF_COAST)) ||
      ((st_next.state_reg == ST_OFF) &&
       (st_next.soff_reg == `HBSS_SOFF_DB_HOLD));
    st_next.term_reg = term_c;
    // events; set wins over a clear in the same cycle
    irq_ev[`HBSS_IRQ_BRAKE] = st_reg.brk_reg & ~st_next.brk_reg;
    irq_ev[`HBSS_IRQ_PWROFF] = st_reg.pwr_reg & ~st_next.pwr_reg;
    if (wr_access && paddr == `HBSS_OFS_IRQ_CLR) begin
      st_next.irq_stat_reg = st_reg.irq_stat_reg & ~pwdata[3:0];
    end
    st_next.irq_stat_reg = st_next.irq_stat_reg | irq_ev;
    // read data and error captured in the setup phase
    if (psel && !penable) begin
      st_next.pslverr_reg = !is_mapped(paddr);
      case (paddr)
        `HBSS_OFS_CFG: st_next.prdata_reg = {27'h0, st_reg.cfg_reg};
        `HBSS_OFS_DELAY: st_next.prdata_reg = {26'h0, st_reg.delay_reg};
        `HBSS_OFS_SPEED: st_next.prdata_reg = {18'h0, st_reg.speed_reg};
        `HBSS_OFS_WAIT: st_next.prdata_reg = {25'h0, st_reg.wait_reg};
        `HBSS_OFS_MAXSPD: st_next.prdata_reg = {18'h0, st_reg.maxspd_reg};
        `HBSS_OFS_STATUS: begin
          st_next.prdata_reg = {20'h0, st_reg.g2_reg, st_reg.soff_reg,
                                st_reg.alloc_reg, st_reg.servo_req_reg,
                                st_reg.db_reg, st_reg.pwr_reg,
                                st_reg.brk_reg, st_reg.state_reg};
        end
        `HBSS_OFS_IRQ_STAT: st_next.prdata_reg = {28'h0, st_reg.irq_stat_reg};
        `HBSS_OFS_IRQ_EN: st_next.prdata_reg = {28'h0, st_reg.irq_en_reg};
        default: st_next.prdata_reg = 32'h0;
      endcase
    end
  end

  // state register; reset gives brake applied and power off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.state_reg <= ST_OFF;
      st_reg.cfg_reg <= `HBSS_CFG_RST;
      st_reg.delay_reg <= `HBSS_DELAY_RST;
      st_reg.speed_reg <= `HBSS_SPEED_RST;
      st_reg.wait_reg <= `HBSS_WAIT_RST;
      st_reg.maxspd_reg <= MAX_SPEED_RST;
      st_reg.db_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ports
  assign prdata = st_reg.prdata_reg;
  assign pready = 1'b1;
  assign pslverr = st_reg.pslverr_reg & psel & penable;
  assign brake_release_out = st_reg.brk_reg;
  assign out_term = st_reg.term_reg;
  assign motor_power_on = st_reg.pwr_reg;
  assign dynamic_brake = st_reg.db_reg;
  assign zero_speed_stop = st_reg.zstop_reg;
  assign irq = |(st_reg.irq_stat_reg & st_reg.irq_en_reg);

  // checks on the sequencing
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_alarm_brake_off: assert property (
    alarm_group_one && stationary |=> !brake_release_out)
    else $error("brake not applied on stationary alarm");
  a_term_or_logic: assert property (
    out_term[0] == ($past(other_out_func[0]) ||
                    (st_reg.alloc_reg == 2'h1 && brake_release_out)))
    else $error("terminal not OR of its functions");
  a_soff_brake_now: assert property (
    st_reg.state_reg == ST_ON && soff_rise && stationary && !alarm_group_one
    && !alarm_group_two |=> !brake_release_out && (motor_power_on ==
    ($past(st_reg.delay_reg) != 6'h0)))
    else $error("servo-off brake or power timing wrong");
  a_delay_hold_pwr: assert property (
    st_reg.state_reg == ST_DELAY |-> motor_power_on && !brake_release_out
    && st_reg.cnt_reg <= 7'(`HBSS_DELAY_MAX))
    else $error("delay state outputs wrong");
  a_alarm_pwr_cut: assert property (
    hard_alarm && st_reg.state_reg != ST_OFF |=> !motor_power_on)
    else $error("power not cut on alarm");
  a_speed_brake_on: assert property (
    st_reg.state_reg == ST_WAIT && below_thr |=> !brake_release_out
    && !motor_power_on)
    else $error("brake not applied below threshold");
  a_wait_timeout: assert property (
    st_reg.state_reg == ST_WAIT && st_reg.cnt_reg == 7'h0 |=>
    st_reg.state_reg == ST_OFF)
    else $error("brake wait timeout missed");
  a_setting_ranges: assert property (
    st_reg.speed_reg <= `HBSS_SPEED_MAX && st_reg.wait_reg >= `HBSS_WAIT_MIN
    && st_reg.wait_reg <= `HBSS_WAIT_MAX)
    else $error("setting out of range");
  a_thr_clamp: assert property (
    st_reg.state_reg == ST_WAIT && motor_speed >= st_reg.maxspd_reg &&
    st_reg.cnt_reg != 7'h0 |=> brake_release_out)
    else $error("threshold not clamped to motor maximum");
  a_zstop_then_seq: assert property (
    st_reg.state_reg == ST_ZSTOP && stationary && !hard_alarm |=>
    st_reg.state_reg == ST_DELAY || st_reg.state_reg == ST_OFF)
    else $error("zero-speed stop did not hand over");
  a_torque_ignore: assert property (
    torque_mode && alarm_group_two && st_reg.state_reg == ST_ON |=>
    st_reg.state_reg != ST_ZSTOP)
    else $error("group two field used in torque mode");
  a_coast_no_db: assert property (
    st_reg.soff_reg == `HBSS_SOFF_COAST |-> !dynamic_brake)
    else $error("dynamic brake in coast mode");

  c_delay_path: cover property (st_reg.state_reg == ST_DELAY ##1
                                st_reg.state_reg == ST_OFF);
  c_wait_speed: cover property (st_reg.state_reg == ST_WAIT && below_thr);
  c_wait_timeout: cover property (st_reg.state_reg == ST_WAIT &&
                                  st_reg.cnt_reg == 7'h0 && !below_thr);
  c_zstop: cover property (st_reg.state_reg == ST_ZSTOP);

endmodule // hbss_sequencer

// ### sim/hbss_partner.sv
// Purpose: host controller and brake relay model for the sequencer
// Assumes: servo commands are level pins, speed is unsigned rpm
// Notes:   every pin moves just after a rising edge, never in between
`timescale 1ns/100ps
module hbss_partner #(
  parameter int RELEASE_CYCLES = 40 // release time plus margin, shortened
) (
  input wire logic pclk,
  input wire logic brake_release_out,
  output logic servo_on_cmd,
  output logic servo_off_cmd,
  output logic [13:0] motor_speed,
  output logic ref_ok
);
  int rel_cnt; // cycles since the relay closed

  // idle host: no command, motor at rest
  initial begin
    servo_on_cmd = 1'b0;
    servo_off_cmd = 1'b0;
    motor_speed = 14'h0000;
    ref_ok = 1'b0;
    rel_cnt = 0;
  end

  // host command pins, held as levels until the next call
  task automatic drive(input logic on, input logic off);
    @(posedge pclk);
    servo_on_cmd <= on;
    servo_off_cmd <= off;
  endtask

  // motor speed seen by the drive's encoder
  task automatic spin(input logic [13:0] v);
    @(posedge pclk);
    motor_speed <= v;
  endtask

  // relay closed long enough before any reference is sent
  always @(posedge pclk) begin
    if (brake_release_out !== 1'b1) begin
      rel_cnt <= 0;
    end else if (rel_cnt < RELEASE_CYCLES) begin
      rel_cnt <= rel_cnt + 1;
    end
    ref_ok <= (rel_cnt >= RELEASE_CYCLES);
  end
endmodule // hbss_partner

// ### sim/holding_brake_stop_sequencer_test.sv
// Purpose: self-checking bench for the brake stop sequencer
// Assumes: tick shortened to 10 cycles, apb with zero wait states
// Notes:   inputs move on rising edges, outputs sampled on falling edges, bus read data on rising edges
`timescale 1ns/100ps
`include "hbss_defs.svh"
module holding_brake_stop_sequencer_test;
  import hbss_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic servo_on_cmd, servo_off_cmd, alarm_group_one, alarm_group_two;
  logic torque_mode, brake_release_out, motor_power_on, dynamic_brake;
  logic zero_speed_stop, irq, ref_ok;
  logic [13:0] motor_speed;
  logic [2:0] other_out_func, out_term;
  int failures = 0;
  int check_count = 0;

  hbss_sequencer #(.TICK_CYCLES(10)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .servo_on_cmd(servo_on_cmd), .servo_off_cmd(servo_off_cmd),
    .alarm_group_one(alarm_group_one), .alarm_group_two(alarm_group_two),
    .torque_mode(torque_mode), .motor_speed(motor_speed),
    .other_out_func(other_out_func), .brake_release_out(brake_release_out),
    .out_term(out_term), .motor_power_on(motor_power_on),
    .dynamic_brake(dynamic_brake), .zero_speed_stop(zero_speed_stop),
    .irq(irq));
  hbss_partner i_host (.pclk(pclk), .brake_release_out(brake_release_out),
    .servo_on_cmd(servo_on_cmd), .servo_off_cmd(servo_off_cmd),
    .motor_speed(motor_speed), .ref_ok(ref_ok));

  // 200 mhz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // verdict, shared by the main sequence and the watchdog
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // word compare, four-state exact
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no wait-state count assumed; only the watchdog ends a hang
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge pclk);
  endtask

  // servo on by a rising edge of the on pin, pin lowered afterwards
  task automatic ton;
    i_host.drive(1'b1, 1'b0);
    cyc(6);
    chk("power on", 32'h1, {31'h0, motor_power_on});
    i_host.drive(1'b0, 1'b0);
  endtask

  // bounded wait for the brake to be applied
  task automatic wait_brake;
    int n = 0;
    while (brake_release_out !== 1'b0 && n < 300) begin
      n++;
      @(negedge pclk);
    end
    chk("brake applied", 32'h0, {31'h0, brake_release_out});
  endtask

  // expected terminals: routed brake bit OR the other functions
  function automatic logic [31:0] texp(input int a, input logic [2:0] o);
    return {29'h0, o | ((a == 0) ? 3'h0 : 3'(3'h1 << (a - 1)))};
  endfunction

  initial begin
    int prev;
    {psel, penable, pwrite, alarm_group_one, alarm_group_two} = 5'h00;
    torque_mode = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    other_out_func = 3'h0; // brake terminal kept unshared
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    cyc(2);
    chk("brake rst", 32'h0, {31'h0, brake_release_out});
    chk("db rst", 32'h1, {31'h0, dynamic_brake});
    rchk(`HBSS_OFS_DELAY, 32'h0, "delay rst");
    rchk(`HBSS_OFS_SPEED, 32'h64, "speed rst");
    rchk(`HBSS_OFS_WAIT, 32'h32, "wait rst");
    rchk(`HBSS_OFS_CFG, 32'h0, "cfg rst");
    rchk(8'h40, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, rerr});
    // range limits of the delay, speed and wait settings
    bus(1'b1, `HBSS_OFS_DELAY, 32'h3f);
    rchk(`HBSS_OFS_DELAY, 32'h32, "delay max");
    bus(1'b1, `HBSS_OFS_SPEED, 32'h3fff);
    rchk(`HBSS_OFS_SPEED, 32'h2710, "speed max");
    bus(1'b1, `HBSS_OFS_WAIT, 32'h5);
    rchk(`HBSS_OFS_WAIT, 32'ha, "wait min");
    bus(1'b1, `HBSS_OFS_WAIT, 32'h7f);
    rchk(`HBSS_OFS_WAIT, 32'h64, "wait max");
    bus(1'b1, `HBSS_OFS_SPEED, 32'h64);
    // stationary servo-off: brake at once, power 3 ticks later
    bus(1'b1, `HBSS_OFS_DELAY, 32'h3);
    ton;
    i_host.drive(1'b0, 1'b1);
    wait_brake;
    cyc(20);
    chk("power held", 32'h1, {31'h0, motor_power_on});
    cyc(15);
    chk("power cut", 32'h0, {31'h0, motor_power_on});
    i_host.drive(1'b0, 1'b0);
    // stationary alarm ignores the delay; interrupt on power cut
    bus(1'b1, `HBSS_OFS_IRQ_CLR, 32'hf);
    bus(1'b1, `HBSS_OFS_IRQ_EN, 32'h2);
    ton;
    chk("irq idle", 32'h0, {31'h0, irq});
    @(posedge pclk);
    alarm_group_one <= 1'b1;
    cyc(2);
    chk("alarm power", 32'h0, {31'h0, motor_power_on});
    chk("alarm brake", 32'h0, {31'h0, brake_release_out});
    chk("irq set", 32'h1, {31'h0, irq});
    bus(1'b0, `HBSS_OFS_IRQ_STAT, 32'h0);
    chk("stat pwr", 32'h1, {31'h0, rdat[1]});
    bus(1'b1, `HBSS_OFS_IRQ_EN, 32'h0);
    cyc(1);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, `HBSS_OFS_IRQ_EN, 32'h2);
    cyc(1);
    chk("irq unmask", 32'h1, {31'h0, irq});
    bus(1'b1, `HBSS_OFS_IRQ_CLR, 32'h2);
    cyc(1);
    chk("irq clear", 32'h0, {31'h0, irq});
    @(posedge pclk);
    alarm_group_one <= 1'b0;
    // rotating group-one alarm under stop methods 0, 1 and 2
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, `HBSS_OFS_CFG, 32'(m << 2));
      bus(1'b1, `HBSS_OFS_RESTART, 32'h1);
      ton;
      i_host.spin(14'd3000);
      @(posedge pclk);
      alarm_group_one <= 1'b1;
      cyc(2);
      chk("rot power", 32'h0, {31'h0, motor_power_on});
      chk("rot brake", 32'h1, {31'h0, brake_release_out});
      chk("stop db", 32'(m != 2), {31'h0, dynamic_brake});
      i_host.spin(14'd50);
      cyc(4);
      chk("slow brake", 32'h0, {31'h0, brake_release_out});
      chk("hold db", 32'(m == 0), {31'h0, dynamic_brake});
      @(posedge pclk);
      alarm_group_one <= 1'b0;
      i_host.spin(14'd0);
    end
    // wait timeout, threshold limited to the motor maximum
    bus(1'b1, `HBSS_OFS_CFG, 32'h0);
    bus(1'b1, `HBSS_OFS_RESTART, 32'h1);
    bus(1'b1, `HBSS_OFS_MAXSPD, 32'd200);
    bus(1'b1, `HBSS_OFS_SPEED, 32'd10000);
    bus(1'b1, `HBSS_OFS_WAIT, 32'ha);
    ton;
    i_host.spin(14'd300);
    @(posedge pclk);
    alarm_group_one <= 1'b1;
    cyc(50);
    chk("clamp brake", 32'h1, {31'h0, brake_release_out});
    cyc(70);
    chk("wait brake", 32'h0, {31'h0, brake_release_out});
    bus(1'b0, `HBSS_OFS_IRQ_STAT, 32'h0);
    chk("stat timeout", 32'h1, {31'h0, rdat[3]});
    alarm_group_one <= 1'b0;
    i_host.spin(14'd0);
    bus(1'b1, `HBSS_OFS_SPEED, 32'h64);
    // group-two alarm: zero-speed, torque mode, group-two field
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, `HBSS_OFS_CFG, (k == 2) ? 32'h10 : 32'h0);
      bus(1'b1, `HBSS_OFS_RESTART, 32'h1);
      torque_mode <= (k == 1);
      ton;
      i_host.spin(14'd3000);
      @(posedge pclk);
      alarm_group_two <= 1'b1;
      cyc(2);
      chk("g2 zstop", 32'(k == 0), {31'h0, zero_speed_stop});
      chk("g2 power", 32'(k == 0), {31'h0, motor_power_on});
      if (k == 0) begin
        i_host.spin(14'd0);
        wait_brake;
        cyc(20);
        chk("zs held", 32'h1, {31'h0, motor_power_on});
        cyc(15);
        chk("zs cut", 32'h0, {31'h0, motor_power_on});
      end
      @(posedge pclk);
      alarm_group_two <= 1'b0;
      torque_mode <= 1'b0;
      i_host.spin(14'd0);
    end
    // terminal routing, live only after restart, or-ed with others
    ton;
    prev = 0;
    for (int a = 0; a < 4; a++) begin
      bus(1'b1, `HBSS_OFS_CFG, 32'(a));
      // other functions never mask the newly routed brake bit; at a = 2 the pending bit 0 is shared
      other_out_func <= 3'h4 >> a;
      cyc(2);
      chk("term pend", texp(prev, 3'h4 >> a), {29'h0, out_term});
      bus(1'b1, `HBSS_OFS_RESTART, 32'h1);
      cyc(2);
      chk("term live", texp(a, 3'h4 >> a), {29'h0, out_term});
      prev = a;
    end
    rchk(`HBSS_OFS_STATUS, 32'h1d9, "status");
    cyc(40);
    chk("ref ok", 32'h1, {31'h0, ref_ok});
    report_and_stop;
  end

  // watchdog well beyond the expected run of under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    $display("MISMATCH watchdog expected done seen hang");
    report_and_stop;
  end
endmodule // holding_brake_stop_sequencer_test
